/* src/pmc_top.sv */
// power saving mode sequencer with apb register slave
//
// The address map and the APB register port were decided locally.
`timescale 1ns/100ps
`include "pmc_defs.svh"
module pmc_top
   import pmc_pkg::*;
#(
   parameter logic [7:0] WFI_OPCODE = 8'h01,
   parameter int PLL_CYC = `PMC_PLL_CYC
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // cpu instruction stream and flags stack
   input wire logic instr_valid,
   input wire logic [7:0] instr_op,
   input wire logic ccr_pop,
   // wake sources
   input wire logic irq_any,
   input wire logic irq_rtc,
   input wire logic irq_at,
   input wire logic irq_halt_wake,
   input wire logic wake_rst_pin_n,
   input wire logic wdg_active,
   // clock enables and controls
   output logic cpu_clk_en,
   output logic per_clk_en,
   output logic lt_clk_en,
   output logic at_clk_en,
   output logic osc_on,
   output logic pll_clk_ok,
   output logic cpu_stopped,
   // cpu sequencing
   output logic irq_mask,
   output logic ccr_push,
   output logic svc_irq,
   output logic fetch_rst_vec,
   output logic wdg_rst,
   output logic [2:0] mode
);

   ////////////////////////////////////////////////////////////
   // declarations
   logic rp_s1_ff, rp_s2_ff, rp_s3_ff, rp_filt_ff, rp_old_ff;
   logic rst_evt;
   logic slow_sel_ff;
   pmc_tcfg_s tcfg_ff;
   pmc_opt_s opt_ff;
   logic slow_act_ff;
   logic [`PMC_DIV_W-1:0] div_ff;
   logic tick32, sys_tick;
   pmc_mode_e mode_ff, nxt_mode;
   logic by_rst_ff, nxt_by_rst;
   logic [`PMC_CNT_W-1:0] cnt_ff;
   logic stab_done, pll_done;
   logic go_svc, go_rst, go_wdg, go_low;
   logic is_halt, is_wfi, ah_en;
   logic apb_setup, apb_done;
   logic sel_main, sel_tcfg, sel_opt, sel_stat, sel_ok;
   logic [31:0] rd_val;
   logic cpu_clk_en_ff, per_clk_en_ff, lt_clk_en_ff, at_clk_en_ff;
   logic osc_on_ff, pll_ok_ff, cpu_stop_ff;
   logic i_bit_ff, push_ff, svc_ff, rvec_ff, wdg_ff;
   logic [31:0] prdata_ff;
   logic pready_ff, pslverr_ff;

   ////////////////////////////////////////////////////////////
   // wake reset pin: three stage synchroniser, then agreement filter
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rp_s1_ff <= 1'b1;
         rp_s2_ff <= 1'b1;
         rp_s3_ff <= 1'b1;
      end else begin
         rp_s1_ff <= wake_rst_pin_n;
         rp_s2_ff <= rp_s1_ff;
         rp_s3_ff <= rp_s2_ff;
      end
   end

   // a level counts only once stages two and three agree
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rp_filt_ff <= 1'b1;
         rp_old_ff <= 1'b1;
      end else begin
         if (rp_s2_ff == rp_s3_ff) begin
            rp_filt_ff <= rp_s2_ff;
         end
         rp_old_ff <= rp_filt_ff;
      end
   end

   // falling edge of the filtered pin is one reset request
   assign rst_evt = rp_old_ff & ~rp_filt_ff;

   ////////////////////////////////////////////////////////////
   // clock divider and glitch free slow switch
   // divider freezes while the oscillator is off
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         div_ff <= '0;
      end else if (mode_ff != PMC_HALT) begin
         div_ff <= div_ff + `PMC_DIV_W'(1);
      end
   end

   assign tick32 = (div_ff == `PMC_DIV_LAST);

   // the selection is only adopted at the divider wrap, so no
   // enable pulse is ever shortened or doubled by a switch
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         slow_act_ff <= 1'b0;
      end else if (tick32) begin
         slow_act_ff <= slow_sel_ff;
      end
   end

   assign sys_tick = slow_act_ff ? tick32 : 1'b1;

   ////////////////////////////////////////////////////////////
   // instruction decode and halt flavour
   assign is_halt = instr_valid & (instr_op == `PMC_HALT_OPCODE);
   assign is_wfi = instr_valid & (instr_op == WFI_OPCODE);
   assign ah_en = tcfg_ff.timebase_irq_enable |
                  (tcfg_ff.overflow_irq_enable & ~tcfg_ff.counter_clock_sel1 &
                   tcfg_ff.counter_clock_sel0);

   assign stab_done = sys_tick & (cnt_ff == `PMC_CNT_W'(`PMC_STAB_CYC - 1));
   assign pll_done = (cnt_ff == `PMC_CNT_W'(PLL_CYC - 1));

   ////////////////////////////////////////////////////////////
   // mode transitions; reset request outranks interrupts
   always_comb begin
      nxt_mode = mode_ff;
      nxt_by_rst = by_rst_ff;
      go_svc = 1'b0;
      go_rst = 1'b0;
      go_wdg = 1'b0;
      go_low = 1'b0;
      unique case (mode_ff)
         PMC_RUN: begin
            if (rst_evt) begin
               go_rst = 1'b1;
            end else if (is_halt) begin
               if (wdg_active & opt_ff.watchdog_halt_option) begin
                  go_wdg = 1'b1;
               end else if (ah_en) begin
                  nxt_mode = PMC_AHALT;
                  go_low = 1'b1;
               end else begin
                  nxt_mode = PMC_HALT;
                  go_low = 1'b1;
               end
            end else if (is_wfi) begin
               nxt_mode = PMC_WAIT;
               go_low = 1'b1;
            end
         end
         PMC_WAIT: begin
            if (rst_evt) begin
               nxt_mode = PMC_RUN;
               go_rst = 1'b1;
            end else if (irq_any) begin
               nxt_mode = PMC_RUN;
               go_svc = 1'b1;
            end
         end
         PMC_AHALT: begin
            if (rst_evt) begin
               nxt_mode = PMC_STAB;
               nxt_by_rst = 1'b1;
            end else if (irq_rtc | irq_at) begin
               nxt_mode = PMC_RUN;
               go_svc = 1'b1;
            end
         end
         PMC_HALT: begin
            if (rst_evt) begin
               nxt_mode = PMC_STAB;
               nxt_by_rst = 1'b1;
            end else if (irq_halt_wake) begin
               nxt_mode = PMC_STAB;
               nxt_by_rst = 1'b0;
            end
         end
         PMC_STAB: begin
            if (stab_done) begin
               if (opt_ff.pll_enable) begin
                  nxt_mode = PMC_PLL;
               end else begin
                  nxt_mode = PMC_RUN;
                  go_rst = by_rst_ff;
                  go_svc = ~by_rst_ff;
               end
            end
         end
         PMC_PLL: begin
            if (pll_done) begin
               nxt_mode = PMC_RUN;
               go_rst = by_rst_ff;
               go_svc = ~by_rst_ff;
            end
         end
         default: begin
            nxt_mode = PMC_RUN;
         end
      endcase
   end

   // mode register
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         mode_ff <= PMC_RUN;
         by_rst_ff <= 1'b0;
      end else begin
         mode_ff <= nxt_mode;
         by_rst_ff <= nxt_by_rst;
      end
   end

   // delay counter, cleared on every mode change
   // stabilisation counts cpu cycles, pll startup counts mclk
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_ff <= '0;
      end else if (nxt_mode != mode_ff) begin
         cnt_ff <= '0;
      end else if (mode_ff == PMC_PLL) begin
         cnt_ff <= cnt_ff + `PMC_CNT_W'(1);
      end else if (mode_ff == PMC_STAB && sys_tick) begin
         cnt_ff <= cnt_ff + `PMC_CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////
   // clock enables per mode
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         cpu_clk_en_ff <= 1'b0;
         per_clk_en_ff <= 1'b0;
         cpu_stop_ff <= 1'b0;
      end else begin
         cpu_clk_en_ff <= sys_tick & (nxt_mode == PMC_RUN);
         per_clk_en_ff <= sys_tick & (nxt_mode == PMC_RUN ||
                                      nxt_mode == PMC_WAIT);
         cpu_stop_ff <= (nxt_mode != PMC_RUN);
      end
   end

   // lite timer stays at osc/32 in run and wait, off in halt; in active halt only
   // the timer picked by the enable condition keeps counting
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         lt_clk_en_ff <= 1'b0;
         at_clk_en_ff <= 1'b0;
      end else begin
         unique case (nxt_mode)
            PMC_RUN, PMC_WAIT: begin
               lt_clk_en_ff <= tick32;
               at_clk_en_ff <= sys_tick;
            end
            PMC_AHALT: begin
               lt_clk_en_ff <= tick32 & tcfg_ff.timebase_irq_enable;
               at_clk_en_ff <= ~tcfg_ff.timebase_irq_enable;
            end
            default: begin
               lt_clk_en_ff <= 1'b0;
               at_clk_en_ff <= 1'b0;
            end
         endcase
      end
   end

   // oscillator off only in halt; pll usable whenever enabled outside halt, stabilisation and pll startup
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         osc_on_ff <= 1'b1;
         pll_ok_ff <= 1'b0;
      end else begin
         osc_on_ff <= (nxt_mode != PMC_HALT);
         pll_ok_ff <= opt_ff.pll_enable & (nxt_mode != PMC_HALT) &
                      (nxt_mode != PMC_STAB) & (nxt_mode != PMC_PLL);
      end
   end

   ////////////////////////////////////////////////////////////
   // interrupt mask: set on service wins over a pop clear
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         i_bit_ff <= 1'b1;
      end else if (go_svc) begin
         i_bit_ff <= 1'b1;
      end else if (go_low) begin
         i_bit_ff <= 1'b0;
      end else if (ccr_pop) begin
         i_bit_ff <= 1'b0;
      end
   end

   // one cycle sequencing pulses
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         push_ff <= 1'b0;
         svc_ff <= 1'b0;
         rvec_ff <= 1'b0;
         wdg_ff <= 1'b0;
      end else begin
         push_ff <= go_svc;
         svc_ff <= go_svc;
         rvec_ff <= go_rst;
         wdg_ff <= go_wdg;
      end
   end

   ////////////////////////////////////////////////////////////
   // apb slave: one wait state, answer registered
   assign apb_setup = psel & penable & ~pready_ff;
   assign apb_done = psel & penable & pready_ff;
   assign sel_main = (paddr == `PMC_OFS_MAIN_CLK);
   assign sel_tcfg = (paddr == `PMC_OFS_TMR_CFG);
   assign sel_opt = (paddr == `PMC_OFS_OPTION);
   assign sel_stat = (paddr == `PMC_OFS_STATUS);
   assign sel_ok = sel_main | sel_tcfg | sel_opt | sel_stat;

   // read mux
   always_comb begin
      rd_val = 32'h0000_0000;
      if (sel_main) begin
         rd_val = {30'h0000_0000, slow_act_ff, slow_sel_ff};
      end else if (sel_tcfg) begin
         rd_val = {28'h000_0000, tcfg_ff};
      end else if (sel_opt) begin
         rd_val = {30'h0000_0000, opt_ff};
      end else if (sel_stat) begin
         rd_val = {26'h000_0000, pll_ok_ff, osc_on_ff, i_bit_ff, mode_ff};
      end
   end

   // handshake and read data
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         pready_ff <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff <= 32'h0000_0000;
      end else begin
         pready_ff <= apb_setup;
         pslverr_ff <= apb_setup & ~sel_ok;
         if (apb_setup && !pwrite) begin
            prdata_ff <= rd_val;
         end
      end
   end

   // writable registers take effect at the completing edge
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         slow_sel_ff <= `PMC_RST_MAIN_CLK;
         tcfg_ff <= `PMC_RST_TMR_CFG;
         opt_ff <= `PMC_RST_OPTION;
      end else if (apb_done && pwrite) begin
         if (sel_main) begin
            slow_sel_ff <= pwdata[0];
         end
         if (sel_tcfg) begin
            tcfg_ff <= pwdata[3:0];
         end
         if (sel_opt) begin
            opt_ff <= pwdata[1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // outputs
   assign prdata = prdata_ff;
   assign pready = pready_ff;
   assign pslverr = pslverr_ff;
   assign cpu_clk_en = cpu_clk_en_ff;
   assign per_clk_en = per_clk_en_ff;
   assign lt_clk_en = lt_clk_en_ff;
   assign at_clk_en = at_clk_en_ff;
   assign osc_on = osc_on_ff;
   assign pll_clk_ok = pll_ok_ff;
   assign cpu_stopped = cpu_stop_ff;
   assign irq_mask = i_bit_ff;
   assign ccr_push = push_ff;
   assign svc_irq = svc_ff;
   assign fetch_rst_vec = rvec_ff;
   assign wdg_rst = wdg_ff;
   assign mode = mode_ff;

endmodule

/* src/pmc_defs.svh */
// constants of the power saving mode controller
// Operation
// - after any reset run from oscillator clock
// - slow_mode_select bit enables or disables slow
// - slow divides system clock by 32
// - wait while slow keeps divided clock
// - wait stops cpu, peripherals keep running
// - entering wait clears interrupt mask bit
// - wait ends on interrupt or reset vector
// - servicing pushes flags, sets mask until pop
// - halt enters active halt when timers enable
// - active halt wakes on rtc, autoreload, reset
// - reset exit waits 256 cycles, irq immediate
// - entering active halt clears interrupt mask
// - active halt runs oscillator and timer only
// - watchdog halt option cleared means no reset
// - otherwise halt instruction enters plain halt
// - halt exit restarts oscillator, waits 256
// - entering halt forces interrupt mask zero
// - halt switches oscillator and clocks off
// - option bit selects watchdog reset on halt
// - pll clock only after startup delay; the code waits only on exits through stabilisation (halt, or active halt by reset), in run pll_clk_ok follows pll_enable
// - opcode 0x8E decodes as halt
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
`define PMC_OFS_MAIN_CLK 12'h000
`define PMC_OFS_TMR_CFG 12'h004
`define PMC_OFS_OPTION 12'h008
`define PMC_OFS_STATUS 12'h00C
`define PMC_HALT_OPCODE 8'h8E
`define PMC_SLOW_DIV 32
`define PMC_DIV_W 5
`define PMC_DIV_LAST 5'h1F
`define PMC_STAB_CYC 256
`define PMC_CNT_W 12
`define PMC_CLK_NS 20
`define PMC_PLL_STARTUP_NS 1000
`define PMC_PLL_CYC ((`PMC_PLL_STARTUP_NS + `PMC_CLK_NS - 1) / `PMC_CLK_NS)
`define PMC_RST_MAIN_CLK 1'b0
`define PMC_RST_TMR_CFG 4'h0
`define PMC_RST_OPTION 2'h0
`endif

/* src/pmc_pkg.sv */
// types of the power saving mode controller
package pmc_pkg;
   typedef enum logic [2:0] {
      PMC_RUN,
      PMC_WAIT,
      PMC_AHALT,
      PMC_HALT,
      PMC_STAB,
      PMC_PLL
   } pmc_mode_e;
   // timer bits that steer the halt choice
   typedef struct packed {
      logic counter_clock_sel1;
      logic counter_clock_sel0;
      logic overflow_irq_enable;
      logic timebase_irq_enable;
   } pmc_tcfg_s;
   // option byte bits
   typedef struct packed {
      logic pll_enable;
      logic watchdog_halt_option;
   } pmc_opt_s;
endpackage

/* test/pmc_top_properties.sv */
// port assertions for the power mode sequencer
`timescale 1ns/100ps
module pmc_top_chk
   import pmc_pkg::*;
#(
   parameter logic [7:0] WFI_OPCODE = 8'h01
) (
   // clock and reset
   input wire logic mclk,
   input wire logic arst_n,
   // requests
   input wire logic instr_valid,
   input wire logic [7:0] instr_op,
   input wire logic irq_any,
   input wire logic irq_rtc,
   input wire logic irq_at,
   input wire logic irq_halt_wake,
   input wire logic wake_rst_pin_n,
   input wire logic wdg_active,
   // answers
   input wire logic osc_on,
   input wire logic irq_mask,
   input wire logic ccr_push,
   input wire logic svc_irq,
   input wire logic [2:0] mode
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   logic [2:0] quiet_ff;
   logic [15:0] stab_ff;
   logic quiet;
   ////////////////////////////////////////////////////////////
   // pin quiet time and wait length; the pin filter acts four cycles late
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         quiet_ff <= 3'h0;
         stab_ff <= 16'h0000;
      end else begin
         quiet_ff <= !wake_rst_pin_n ? 3'h0 : quiet_ff + {2'h0, quiet_ff != 3'h7};
         stab_ff <= (mode == PMC_STAB) ? stab_ff + 16'h0001 : 16'h0000;
      end
   end
   assign quiet = quiet_ff[2] & quiet_ff[1] & wake_rst_pin_n;
   ////////////////////////////////////////////////////////////
   // an instruction taken in run, and the service of a waking request
   sequence s_run_op(logic [7:0] code);
      instr_valid && instr_op == code && mode == PMC_RUN && quiet;
   endsequence
   sequence s_serve;
      mode == PMC_RUN && svc_irq && ccr_push && irq_mask;
   endsequence
   AST_RESET_RUN: assert property ($rose(arst_n) |-> mode == PMC_RUN && osc_on)
      else $error("mode after reset is not run");
   AST_WFI_ENTRY: assert property (s_run_op(WFI_OPCODE) |=> mode == PMC_WAIT && !irq_mask)
      else $error("wait entry wrong");
   AST_WAIT_WAKE: assert property (mode == PMC_WAIT && irq_any && quiet |=> s_serve)
      else $error("wait did not wake into service");
   AST_HALT_ENTRY: assert property (s_run_op(8'h8E) && !wdg_active |=>
      mode inside {PMC_AHALT, PMC_HALT} && !irq_mask) else $error("halt entry wrong");
   AST_AHALT_WAKE: assert property (mode == PMC_AHALT && (irq_rtc || irq_at) && quiet
      |=> s_serve) else $error("active halt did not wake");
   AST_AHALT_HOLD: assert property (mode == PMC_AHALT && !irq_rtc && !irq_at && quiet
      |=> mode == PMC_AHALT) else $error("active halt left without cause");
   AST_OSC_LEVEL: assert property (osc_on == (mode != PMC_HALT))
      else $error("oscillator level wrong");
   AST_HALT_WAKE: assert property (mode == PMC_HALT && irq_halt_wake && quiet
      |=> mode == PMC_STAB && osc_on) else $error("halt did not restart");
   // the counter sees every cycle of the wait, so 256 cycles read as 256, one above the bound
   AST_STAB_LEN: assert property ($fell(mode == PMC_STAB) |-> stab_ff >= 16'h00FF)
      else $error("stabilisation wait too short");
endmodule
bind pmc_top pmc_top_chk #(.WFI_OPCODE(WFI_OPCODE)) u_chk (.mclk, .arst_n, .instr_valid,
   .instr_op, .irq_any, .irq_rtc, .irq_at, .irq_halt_wake, .wake_rst_pin_n, .wdg_active,
   .osc_on, .irq_mask, .ccr_push, .svc_irq, .mode);

/* test/power_saving_mode_control_tb.sv */
// self-checking bench of the power mode sequencer
`timescale 1ns/100ps
module power_saving_mode_control_tb;
   import pmc_pkg::*;
   logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, ccr_pop, h;
   logic irq_any, irq_rtc, irq_at, irq_halt_wake, wake_rst_pin_n, wdg_active, instr_valid;
   logic cpu_clk_en, per_clk_en, lt_clk_en, at_clk_en, osc_on, pll_clk_ok, cpu_stopped;
   logic irq_mask, ccr_push, svc_irq, fetch_rst_vec, wdg_rst;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, d;
   logic [7:0] instr_op;
   logic [2:0] mode;
   logic [32:0] aq[$], mq[$];
   logic [2:0] eq[$];
   int bad_count, check_count, cyc, n, m, k;
   pmc_top #(.PLL_CYC(2)) dut (.mclk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .instr_valid, .instr_op, .ccr_pop, .irq_any, .irq_rtc,
      .irq_at, .irq_halt_wake, .wake_rst_pin_n, .wdg_active, .cpu_clk_en, .per_clk_en,
      .lt_clk_en, .at_clk_en, .osc_on, .pll_clk_ok, .cpu_stopped, .irq_mask, .ccr_push,
      .svc_irq, .fetch_rst_vec, .wdg_rst, .mode);
   ////////////////////////////////////////////////////////////
   task automatic end_sim();
      $display("Comparisons %0d, mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [32:0] g, input logic [32:0] e, input logic [32:0] k);
      check_count++;
      if ((g & k) !== (e & k)) begin
         bad_count++;
         $display("Error at %0t: got %h, expected %h", $time, g, e);
      end
   endtask
   // state compare: mode and two flags
   task automatic st(input logic [4:0] g, input logic [4:0] e);
      cmp({28'h000_0000, g}, {28'h000_0000, e}, '1);
   endtask
   // apb transfer; the expected answer is noted first
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
         input logic [32:0] e, input logic [32:0] k);
      aq.push_back(e);
      mq.push_back(k);
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'b1;
      // the request stands until the rising edge that sees pready high
      do @(posedge mclk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] wd);
      apb(1'b1, a, wd, 33'h0, 33'h1_0000_0000);
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0, {1'b0, e}, '1);
   endtask
   // one instruction; the following falling edge sees its effect
   task automatic op(input logic [7:0] code);
      @(posedge mclk);
      instr_valid <= 1'b1;
      instr_op <= code;
      @(posedge mclk);
      instr_valid <= 1'b0;
      @(negedge mclk);
   endtask
   // back in run, every wake source is withdrawn
   task automatic wait_run();
      do @(negedge mclk); while (mode !== 3'h0);
      @(posedge mclk);
      {irq_any, irq_rtc, irq_at, irq_halt_wake, wdg_active} <= 5'h00;
      wake_rst_pin_n <= 1'b1;
      @(negedge mclk);
   endtask
   // enable pulses seen over 64 cycles
   task automatic tally();
      n = 0;
      m = 0;
      k = 0;
      repeat (64) begin
         @(negedge mclk);
         n += per_clk_en;
         m += lt_clk_en;
         k += cpu_clk_en;
      end
   endtask
   ////////////////////////////////////////////////////////////
   // clock
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // answers are matched in order against the drivers' notes; hangs are cut short
   always @(posedge mclk) begin
      if (pready === 1'b1) begin
         cmp({pslverr, prdata}, aq.size() ? aq.pop_front() : 'x, mq.size() ? mq.pop_front() : '1);
      end
      if ({svc_irq, fetch_rst_vec, wdg_rst} !== 3'h0) begin
         cmp({30'h0, svc_irq, fetch_rst_vec, wdg_rst}, eq.size() ? {30'h0, eq.pop_front()} : 'x, '1);
      end
      cyc++;
      if (cyc == 12000) begin
         bad_count++;
         end_sim();
      end
   end
   // main sequence
   initial begin
      {arst_n, psel, penable, pwrite, instr_valid, ccr_pop, irq_any, irq_rtc} = 8'h00;
      {irq_at, irq_halt_wake, wdg_active, paddr, pwdata, instr_op} = '0;
      wake_rst_pin_n = 1'b1;
      void'($urandom(88694));
      repeat (6) @(posedge mclk);
      arst_n <= 1'b1;
      @(negedge mclk);
      st({mode, irq_mask, osc_on}, {PMC_RUN, 2'b11});
      rd(12'h000, 32'h0);
      rd(12'h008, 32'h0);
      wr(12'h00C, 32'hFFFF_FFFF);
      apb(1'b0, 12'h00C, 32'h0, 33'h0_0000_0018, 33'h1_FFFF_FFDF);
      apb(1'b0, 12'h010, 32'h0, 33'h1_0000_0000, '1);
      apb(1'b1, 12'h010, 32'h5, 33'h1_0000_0000, 33'h1_0000_0000);
      d = $urandom;
      wr(12'h004, d);
      rd(12'h004, {28'h000_0000, d[3:0]});
      // every timer setting, refused wake sources first
      for (int i = 0; i < 16; i++) begin
         d = 32'(i);
         wr(12'h004, d);
         h = d[0] || (d[1] && d[2] && !d[3]);
         eq.push_back(3'h4);
         // a running watchdog must not matter while its halt option is clear
         wdg_active <= 1'($urandom);
         op(8'h8E);
         st({mode, irq_mask, osc_on}, h ? {PMC_AHALT, 2'b01} : {PMC_HALT, 2'b00});
         @(posedge mclk);
         irq_any <= 1'($urandom);
         irq_halt_wake <= h;
         irq_rtc <= !h;
         repeat (3) @(negedge mclk);
         st({mode, irq_mask, osc_on}, h ? {PMC_AHALT, 2'b01} : {PMC_HALT, 2'b00});
         // cpu held; only the picked timer keeps its enable in active halt
         cmp(33'({cpu_stopped, cpu_clk_en, at_clk_en}), 33'({2'b10, h && !d[0]}), '1);
         @(posedge mclk);
         irq_halt_wake <= !h;
         irq_rtc <= !h || !d[1];
         irq_at <= h && d[1];
         wait_run();
      end
      // wait with a request already pending, then flags popped
      @(posedge mclk);
      irq_any <= 1'b1;
      eq.push_back(3'h4);
      op(8'h01);
      st({mode, irq_mask, osc_on}, {PMC_WAIT, 2'b01});
      wait_run();
      st({mode, irq_mask, osc_on}, {PMC_RUN, 2'b11});
      @(posedge mclk);
      ccr_pop <= 1'b1;
      @(posedge mclk);
      ccr_pop <= 1'b0;
      @(negedge mclk);
      st({mode, irq_mask, osc_on}, {PMC_RUN, 2'b01});
      // watchdog reset instead of halt, then halt kept and left by the reset pin
      wr(12'h008, 32'h1);
      wdg_active <= 1'b1;
      eq.push_back(3'h1);
      op(8'h8E);
      @(negedge mclk);
      st({mode, 1'b0, osc_on}, {PMC_RUN, 2'b01});
      wr(12'h008, 32'h2);
      wr(12'h004, 32'h1);
      op(8'h8E);
      st({mode, irq_mask, osc_on}, {PMC_AHALT, 2'b01});
      eq.push_back(3'h2);
      @(posedge mclk);
      wake_rst_pin_n <= 1'b0;
      do @(negedge mclk); while (mode !== PMC_PLL);
      st({mode, pll_clk_ok, osc_on}, {PMC_PLL, 2'b01});
      wait_run();
      st({mode, pll_clk_ok, osc_on}, {PMC_RUN, 2'b11});
      // slow wait, then full rate again
      wr(12'h000, 32'h1);
      repeat (40) @(posedge mclk);
      rd(12'h000, 32'h3);
      op(8'h01);
      tally();
      cmp(33'(n), 33'h2, '1);
      cmp(33'(m), 33'h2, '1);
      cmp(33'(k), 33'h0, '1);
      eq.push_back(3'h4);
      @(posedge mclk);
      irq_any <= 1'b1;
      wait_run();
      wr(12'h000, 32'h0);
      repeat (40) @(posedge mclk);
      tally();
      cmp(33'(n), 33'h40, '1);
      cmp(33'(k), 33'h40, '1);
      cmp(33'(m), 33'h2, '1);
      end_sim();
   end
endmodule
